// File: ecg_aux_pkg.sv
package ecg_aux_pkg;

  // ==========================================================================
  // Register addresses.
  localparam logic [7:0] ADDR_PACE_SUMMARY = 8'h1a;
  localparam logic [7:0] ADDR_RESP_MAGNITUDE = 8'h1b;
  localparam logic [7:0] ADDR_RESP_PHASE = 8'h1c;
  localparam logic [7:0] ADDR_ELECTRODE_STATUS = 8'h1d;
  localparam logic [7:0] ADDR_PACE_PRECISE_BASE = 8'h3a;

  // ==========================================================================
  // Widths and field layout.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int PACE_CHANNELS = 3;
  localparam int ELECTRODES = 6;
  localparam int PACE_LANE_W = 8;
  localparam int PACE_WIDTH_W = 3;
  localparam int PACE_HEIGHT_W = 4;
  localparam int PACE_FLAG_POS = 7;
  localparam int PACE_WIDTH_LSB = 4;
  localparam int ELEC_STATUS_LSB = 18;
  localparam int ELEC_STATUS_MSB = 23;

  // ==========================================================================
  // Reset values.
  localparam logic [23:0] REG_RESET = 24'h000000;
  localparam logic [15:0] HALF_PAD = 16'h0000;

  // ==========================================================================
  // Frame word slots; respiration phase never has a slot.
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_PACE = 2'b01,
    FS_MAG = 2'b10,
    FS_STATUS = 2'b11
  } frame_slot_t;

endpackage

// File: ecg_aux_readback_registers.sv
// What this block does
// - At the highest data rate in frame mode each framed 32-bit word goes out as two 16-bit halves, upper first.
// - Register read commands always return the complete 32-bit word, whatever the data rate.
// - The pace summary packs a detected flag, a log2 width code and a log2 height code per channel in one word.
// - Three more registers give the precise width and height of each pace channel.
// - The respiration magnitude register holds a 24-bit unsigned magnitude in its low bits.
// - The respiration phase register holds a 24-bit binary angle, one LSB being one turn over 2^24.
// - The respiration phase is never framed and is only returned to a register read of its address.
// - Electrode status sits in bits 23..18 as right leg drive, left arm, left leg, right arm, chest one, chest two.
// - With both ac and dc detection enabled the non-common electrode bits show only the ac result.
// - Common electrodes report dc detection only, never an ac result.
// - Pace summary, magnitude and phase sit at consecutive addresses and reset to zero.
// - Lead-off bits accumulate over a frame and clear when the frame is loaded for output.
// - A pace flag is set on the trailing edge of a pace pulse and marks a pulse within the frame.
`timescale 1ns/100ps
module ecg_aux_readback_registers
  import ecg_aux_pkg::*;
#(
  parameter logic [ELECTRODES-1:0] COMMON_MASK = 6'h20
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic SRST_I,
  // Pace detector results.
  input wire logic [PACE_CHANNELS-1:0] PACE_PULSE_I,
  input wire logic [PACE_CHANNELS*PACE_WIDTH_W-1:0] PACE_WIDTH_LOG_I,
  input wire logic [PACE_CHANNELS*PACE_HEIGHT_W-1:0] PACE_HEIGHT_LOG_I,
  input wire logic [PACE_CHANNELS*DATA_W-1:0] PACE_PRECISE_I,
  // Respiration results.
  input wire logic RESP_UPDATE_I,
  input wire logic [DATA_W-1:0] RESP_MAG_I,
  input wire logic [DATA_W-1:0] RESP_PHASE_I,
  // Lead-off detection.
  input wire logic AC_DETECT_EN_I,
  input wire logic DC_DETECT_EN_I,
  input wire logic [ELECTRODES-1:0] AC_DETACH_I,
  input wire logic [ELECTRODES-1:0] DC_DETACH_I,
  // Frame output.
  input wire logic FRAME_LOAD_I,
  input wire logic FAST_RATE_I,
  input wire logic FRM_READY_I,
  output logic FRM_VALID_O,
  output logic [WORD_W-1:0] FRM_DATA_O,
  // Register read commands.
  input wire logic RD_EN_I,
  input wire logic [ADDR_W-1:0] RD_ADDR_I,
  output logic RD_VALID_O,
  output logic [WORD_W-1:0] RD_DATA_O
);

  // ==========================================================================
  // Pace capture.
  logic [PACE_CHANNELS-1:0] pace_prev;
  logic [PACE_CHANNELS-1:0] pace_trailing;
  logic [PACE_CHANNELS-1:0] pace_acc;
  logic [PACE_CHANNELS*PACE_WIDTH_W-1:0] pace_width;
  logic [PACE_CHANNELS*PACE_HEIGHT_W-1:0] pace_height;
  logic [PACE_CHANNELS*DATA_W-1:0] pace_precise;
  logic [DATA_W-1:0] pace_summary;
  logic [DATA_W-1:0] next_pace_summary;

  assign pace_trailing = pace_prev & ~PACE_PULSE_I;

  genvar c;
  generate
    for (c = 0; c < PACE_CHANNELS; c++) begin : g_pace
      always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
          pace_prev[c] <= 1'b0;
          pace_acc[c] <= 1'b0;
          pace_width[c*PACE_WIDTH_W +: PACE_WIDTH_W] <= '0;
          pace_height[c*PACE_HEIGHT_W +: PACE_HEIGHT_W] <= '0;
          pace_precise[c*DATA_W +: DATA_W] <= REG_RESET;
        end else begin
          pace_prev[c] <= PACE_PULSE_I[c];
          // A trailing edge in the load cycle goes into the outgoing frame.
          pace_acc[c] <= FRAME_LOAD_I ? 1'b0 : (pace_acc[c] | pace_trailing[c]);
          if (pace_trailing[c]) begin
            pace_width[c*PACE_WIDTH_W +: PACE_WIDTH_W] <= PACE_WIDTH_LOG_I[c*PACE_WIDTH_W +: PACE_WIDTH_W];
            pace_height[c*PACE_HEIGHT_W +: PACE_HEIGHT_W] <= PACE_HEIGHT_LOG_I[c*PACE_HEIGHT_W +: PACE_HEIGHT_W];
            pace_precise[c*DATA_W +: DATA_W] <= PACE_PRECISE_I[c*DATA_W +: DATA_W];
          end
        end
      end
      // Same-cycle codes are used when the trailing edge meets the frame load.
      assign next_pace_summary[c*PACE_LANE_W +: PACE_LANE_W] = {
        pace_acc[c] | pace_trailing[c],
        pace_trailing[c] ? PACE_WIDTH_LOG_I[c*PACE_WIDTH_W +: PACE_WIDTH_W]
                         : pace_width[c*PACE_WIDTH_W +: PACE_WIDTH_W],
        pace_trailing[c] ? PACE_HEIGHT_LOG_I[c*PACE_HEIGHT_W +: PACE_HEIGHT_W]
                         : pace_height[c*PACE_HEIGHT_W +: PACE_HEIGHT_W]};
    end
  endgenerate

  // ==========================================================================
  // Lead-off selection and accumulation.
  logic [ELECTRODES-1:0] electrode_sel;
  logic [ELECTRODES-1:0] loff_acc;
  logic [ELECTRODES-1:0] loff_status;
  wire logic [ELECTRODES-1:0] dc_gated = DC_DETACH_I & {ELECTRODES{DC_DETECT_EN_I}};
  wire logic [ELECTRODES-1:0] ac_or_dc = AC_DETECT_EN_I ? AC_DETACH_I : dc_gated;

  assign electrode_sel = (COMMON_MASK & dc_gated) | (~COMMON_MASK & ac_or_dc);

  // ==========================================================================
  // Result registers.
  logic [DATA_W-1:0] respiration_magnitude;
  logic [DATA_W-1:0] respiration_phase;
  wire logic [DATA_W-1:0] electrode_status = {loff_status, {ELEC_STATUS_LSB{1'b0}}};

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pace_summary <= REG_RESET;
      respiration_magnitude <= REG_RESET;
      respiration_phase <= REG_RESET;
      loff_acc <= '0;
      loff_status <= '0;
    end else begin
      if (FRAME_LOAD_I) begin
        pace_summary <= next_pace_summary;
        loff_status <= loff_acc | electrode_sel;
      end
      loff_acc <= FRAME_LOAD_I ? '0 : (loff_acc | electrode_sel);
      if (RESP_UPDATE_I) begin
        respiration_magnitude <= RESP_MAG_I;
        respiration_phase <= RESP_PHASE_I;
      end
    end
  end

  // ==========================================================================
  // Register read decode.
  wire logic [ADDR_W-1:0] precise_index = RD_ADDR_I - ADDR_PACE_PRECISE_BASE;
  wire logic precise_hit = precise_index < ADDR_W'(PACE_CHANNELS);
  logic [DATA_W-1:0] rd_value;

  always_comb begin
    rd_value = REG_RESET;
    case (RD_ADDR_I)
      ADDR_PACE_SUMMARY: rd_value = pace_summary;
      ADDR_RESP_MAGNITUDE: rd_value = respiration_magnitude;
      ADDR_RESP_PHASE: rd_value = respiration_phase;
      ADDR_ELECTRODE_STATUS: rd_value = electrode_status;
      default: rd_value = precise_hit ? pace_precise[precise_index[1:0]*DATA_W +: DATA_W] : REG_RESET;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= '0;
    end else begin
      RD_VALID_O <= RD_EN_I;
      RD_DATA_O <= RD_EN_I ? {RD_ADDR_I, rd_value} : '0;
    end
  end

  // ==========================================================================
  // Frame word sequencer.
  frame_slot_t slot;
  frame_slot_t next_slot;
  logic half;
  logic next_half;
  logic load_pending;
  logic [WORD_W-1:0] full_word;
  wire logic advance = (slot != FS_IDLE) && FRM_READY_I;

  always_comb begin
    next_slot = slot;
    next_half = half;
    if (load_pending) begin
      next_slot = FS_PACE;
      next_half = 1'b0;
    end else if (advance) begin
      if (FAST_RATE_I && !half) begin
        next_half = 1'b1;
      end else begin
        next_half = 1'b0;
        case (slot)
          FS_PACE: next_slot = FS_MAG;
          FS_MAG: next_slot = FS_STATUS;
          default: next_slot = FS_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (next_slot)
      FS_PACE: full_word = {ADDR_PACE_SUMMARY, pace_summary};
      FS_MAG: full_word = {ADDR_RESP_MAGNITUDE, respiration_magnitude};
      FS_STATUS: full_word = {ADDR_ELECTRODE_STATUS, electrode_status};
      default: full_word = '0;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      slot <= FS_IDLE;
      half <= 1'b0;
      load_pending <= 1'b0;
      FRM_VALID_O <= 1'b0;
      FRM_DATA_O <= '0;
    end else begin
      slot <= next_slot;
      half <= next_half;
      load_pending <= FRAME_LOAD_I;
      FRM_VALID_O <= next_slot != FS_IDLE;
      if (!FAST_RATE_I) begin
        FRM_DATA_O <= full_word;
      end else begin
        FRM_DATA_O <= {HALF_PAD, next_half ? full_word[HALF_W-1:0] : full_word[WORD_W-1:HALF_W]};
      end
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_load_fast;
    FRAME_LOAD_I ##1 FAST_RATE_I;
  endsequence
  sequence s_load_full;
    FRAME_LOAD_I ##1 !FAST_RATE_I;
  endsequence

  a_fast_split: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_load_fast |=> FRM_VALID_O && FRM_DATA_O == {HALF_PAD, ADDR_PACE_SUMMARY, pace_summary[DATA_W-1:HALF_W]})
    else $error("Fast frame did not start with upper pace half.");
  a_full_frame: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_load_full |=> FRM_VALID_O && FRM_DATA_O == {ADDR_PACE_SUMMARY, pace_summary})
    else $error("Full frame did not start with pace word.");
  a_read_whole: assert property (@(posedge CLK_I) disable iff (SRST_I)
    RD_EN_I |=> RD_VALID_O && RD_DATA_O[WORD_W-1:DATA_W] == $past(RD_ADDR_I))
    else $error("Read answer missing or wrong address byte.");
  a_pace_pack: assert property (@(posedge CLK_I) disable iff (SRST_I)
    ($fell(PACE_PULSE_I[0]) && FRAME_LOAD_I) |=>
      pace_summary[PACE_FLAG_POS:PACE_WIDTH_LSB] == {1'b1, $past(PACE_WIDTH_LOG_I[PACE_WIDTH_W-1:0])})
    else $error("Pace lane not packed from trailing edge.");
  a_precise_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (RD_EN_I && RD_ADDR_I == ADDR_PACE_PRECISE_BASE) |=> RD_DATA_O[DATA_W-1:0] == $past(pace_precise[DATA_W-1:0]))
    else $error("Precise pace read wrong.");
  a_mag_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (RD_EN_I && RD_ADDR_I == ADDR_RESP_MAGNITUDE) |=> RD_DATA_O[DATA_W-1:0] == $past(respiration_magnitude))
    else $error("Magnitude read wrong.");
  a_phase_store: assert property (@(posedge CLK_I) disable iff (SRST_I)
    RESP_UPDATE_I |=> respiration_phase == $past(RESP_PHASE_I))
    else $error("Phase not stored.");
  a_phase_unframed: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (FRM_VALID_O && !$past(FAST_RATE_I)) |-> FRM_DATA_O[WORD_W-1:DATA_W] != ADDR_RESP_PHASE)
    else $error("Phase appeared in frame.");
  a_status_layout: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (RD_EN_I && RD_ADDR_I == ADDR_ELECTRODE_STATUS) |=>
      RD_DATA_O[DATA_W-1:0] == {$past(loff_status), {ELEC_STATUS_LSB{1'b0}}})
    else $error("Electrode status layout wrong.");
  a_ac_priority: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (AC_DETECT_EN_I && DC_DETECT_EN_I) |-> (electrode_sel & ~COMMON_MASK) == (AC_DETACH_I & ~COMMON_MASK))
    else $error("Ac result not preferred.");
  a_common_dc: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (electrode_sel & COMMON_MASK) == (dc_gated & COMMON_MASK))
    else $error("Common electrode not dc only.");
  a_reset_zero: assert property (@(posedge CLK_I)
    SRST_I |=> pace_summary == REG_RESET && respiration_magnitude == REG_RESET && respiration_phase == REG_RESET)
    else $error("Result registers not cleared by reset.");
  a_loff_clear: assert property (@(posedge CLK_I) disable iff (SRST_I)
    FRAME_LOAD_I |=> loff_acc == '0 && loff_status == $past(loff_acc | electrode_sel))
    else $error("Lead-off bits not cleared by frame load.");

endmodule // ecg_aux_readback_registers

// File: ecg_aux_readback_registers_tb.sv
`timescale 1ns/100ps
module ecg_aux_readback_registers_tb;
  import ecg_aux_pkg::*;
  logic clk = 0, srst = 1, resp_update = 0, ac_en = 0, dc_en = 0, frame_load = 0, fast_rate = 0;
  logic rd_en = 0, slow = 0, frm_ready, frm_valid, rd_valid;
  logic [2:0] pace_pulse = 0;
  logic [8:0] width_log = 0;
  logic [11:0] height_log = 0;
  logic [71:0] precise = 0;
  logic [23:0] resp_mag = 0, resp_phase = 0;
  logic [5:0] ac_detach = 0, dc_detach = 0;
  logic [7:0] rd_addr = 0;
  logic [31:0] frm_data, rd_data;
  int fails = 0, checks = 0;

  always #4 clk = ~clk;

  ecg_aux_readback_registers ecg_aux_readback_registers_inst (.CLK_I(clk), .SRST_I(srst),
    .PACE_PULSE_I(pace_pulse), .PACE_WIDTH_LOG_I(width_log), .PACE_HEIGHT_LOG_I(height_log),
    .PACE_PRECISE_I(precise), .RESP_UPDATE_I(resp_update), .RESP_MAG_I(resp_mag), .RESP_PHASE_I(resp_phase),
    .AC_DETECT_EN_I(ac_en), .DC_DETECT_EN_I(dc_en), .AC_DETACH_I(ac_detach), .DC_DETACH_I(dc_detach),
    .FRAME_LOAD_I(frame_load), .FAST_RATE_I(fast_rate), .FRM_READY_I(frm_ready), .FRM_VALID_O(frm_valid),
    .FRM_DATA_O(frm_data), .RD_EN_I(rd_en), .RD_ADDR_I(rd_addr), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data));
  frame_host_model frame_host_model_inst (.clk_i(clk), .slow_i(slow), .valid_i(frm_valid),
    .data_i(frm_data), .ready_o(frm_ready));

  // ==========================================================================
  // Shared tasks.
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic read_reg(input logic [7:0] addr, input logic [23:0] exp);
    @(negedge clk);
    rd_en = 1;
    rd_addr = addr;
    @(negedge clk);
    rd_en = 0;
    check("read valid", 32'h1, {31'h0, rd_valid});
    check("read data", {addr, exp}, rd_data);
    @(negedge clk);
    check("read release", 32'h0, rd_data | {31'h0, rd_valid});
  endtask

  // Loads a frame, ends any pace pulse in the load cycle, drops the lead-off levels and checks the word count.
  task automatic get_frame(input int n, output int base);
    base = frame_host_model_inst.count;
    @(negedge clk);
    frame_load = 1;
    pace_pulse = 0;
    @(negedge clk);
    frame_load = 0;
    ac_detach = 0;
    dc_detach = 0;
    for (int i = 0; i < 60 && frame_host_model_inst.count < base + n; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    check("frame word count", n, frame_host_model_inst.count - base);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic test_reset;
    read_reg(8'h1a, 24'h000000);
    read_reg(8'h1b, 24'h000000);
    read_reg(8'h1c, 24'h000000);
    read_reg(8'h1d, 24'h000000);
    read_reg(8'h3a, 24'h000000);
  endtask

  task automatic test_resp;
    logic [23:0] angles [0:2];
    angles = '{24'h400000, 24'h800000, 24'hc00000};
    foreach (angles[i]) begin
      @(negedge clk);
      resp_mag = 24'h89abcd - i;
      resp_phase = angles[i];
      resp_update = 1;
      @(negedge clk);
      resp_update = 0;
      read_reg(8'h1b, 24'h89abcd - i);
      read_reg(8'h1c, angles[i]);
    end
  endtask

  task automatic test_pace_frame;
    int b;
    @(negedge clk);
    width_log = 9'b010_000_101;
    height_log = 12'h70a;
    precise = {24'h333333, 24'h000000, 24'h111111};
    ac_en = 1;
    dc_en = 1;
    ac_detach = 6'b100110;
    dc_detach = 6'b010001;
    pace_pulse = 3'b101;
    repeat (2) @(negedge clk);
    // Channel 3 ends early and channel 1 in the load cycle; the lead-off levels drop so only the accumulator holds them.
    pace_pulse = 3'b001;
    ac_detach = 0;
    dc_detach = 0;
    repeat (2) @(negedge clk);
    get_frame(3, b);
    check("frame pace", {8'h1a, 24'ha700da}, frame_host_model_inst.words[b]);
    check("frame magnitude", {8'h1b, 24'h89abcb}, frame_host_model_inst.words[b + 1]);
    check("frame status", {8'h1d, 24'h180000}, frame_host_model_inst.words[b + 2]);
    read_reg(8'h3a, 24'h111111);
    read_reg(8'h3b, 24'h000000);
    read_reg(8'h3c, 24'h333333);
  endtask

  task automatic test_fast_frame;
    int b;
    logic [15:0] halves [0:5];
    halves = '{16'h1a27, 16'h005a, 16'h1b89, 16'habcb, 16'h1d00, 16'h0000};
    fast_rate = 1;
    slow = 1;
    get_frame(6, b);
    foreach (halves[i]) check("fast half", {16'h0000, halves[i]}, frame_host_model_inst.words[b + i]);
    read_reg(8'h1a, 24'h27005a);
  endtask

  initial begin
    #200000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (5) @(negedge clk);
    srst = 0;
    test_reset();
    test_resp();
    test_pace_frame();
    test_fast_frame();
    finish_test();
  end
endmodule // ecg_aux_readback_registers_tb

// File: frame_host_model.sv
`timescale 1ns/100ps
module frame_host_model (
  // Clock and pacing.
  input wire logic clk_i,
  input wire logic slow_i,
  // Frame words from the device.
  input wire logic valid_i,
  input wire logic [31:0] data_i,
  output logic ready_o
);
  logic [31:0] words [0:15];
  int count = 0;
  logic phase = 1'b0;

  // A slow host accepts only every other cycle.
  always @(negedge clk_i) begin
    phase <= ~phase;
  end
  assign ready_o = slow_i ? phase : 1'b1;

  // Only framed words are kept here; the phase is fetched by a register read.
  always @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      words[count] <= data_i;
      count <= count + 1;
    end
  end
endmodule // frame_host_model
